// ### include/smpz_pkg.sv
// shared constants for the phase-zero serial master
package smpz_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int SMPZ_DATA_W = 8; // register data and serial word width
   localparam int SMPZ_ADDR_W = 3; // register index width
   localparam int SMPZ_BAUD_W = 7; // divider field, 0 to 127
   localparam int SMPZ_CNT_W = 8; // half-period counter, holds up to 128
   localparam int SMPZ_BUF_DEPTH = 2; // entries in each word buffer

   ////////////////////////////////////////////////////////////////////////////////
   // register indices
   localparam logic [2:0] SMPZ_ADDR_CFG = 3'h0; // config_control_reg
   localparam logic [2:0] SMPZ_ADDR_OPCTL = 3'h1; // operation_control_reg
   localparam logic [2:0] SMPZ_ADDR_BAUD = 3'h2; // baud_divider
   localparam logic [2:0] SMPZ_ADDR_TX = 3'h3; // write pushes a word
   localparam logic [2:0] SMPZ_ADDR_RX = 3'h4; // read pops a word
   localparam logic [2:0] SMPZ_ADDR_STAT = 3'h5; // status, read only

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int SMPZ_POL_BIT = 6; // clock polarity in config_control_reg
   localparam int SMPZ_ROLE_BIT = 2; // master select in operation_control_reg
   localparam int SMPZ_PHASE_BIT = 3; // clock phase in operation_control_reg
   localparam int SMPZ_STAT_TXROOM = 0; // transmit buffer can take a word
   localparam int SMPZ_STAT_RXVALID = 1; // receive buffer holds a word
   localparam int SMPZ_STAT_BUSY = 2; // a word is on the line

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] SMPZ_CFG_RESET = 8'h00;
   localparam logic [7:0] SMPZ_OPCTL_RESET = 8'h00;
   localparam logic [6:0] SMPZ_BAUD_RESET = 7'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // serial timing in peripheral clock cycles
   localparam logic [6:0] SMPZ_DIV_FIXED_MAX = 7'h03; // divider at or below uses fixed
   localparam logic [7:0] SMPZ_FIXED_PERIOD = 8'h04; // four-cycle serial period
   localparam logic [2:0] SMPZ_LAST_BIT = 3'h7; // index of the final bit

   // shifter states
   typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_ACTIVE, ST_IDLEHALF} smpz_state_t;

endpackage

// ### src/smpz_top.sv
// Contract
// - serial period is four or divider plus one
// - even divisor gives equal clock halves
// - odd divisor shortens non-idle half by half
// - polarity bit picks edges and idle level
// - runs only as master with phase zero
// - data launched on leading clock edge
// - incoming data sampled on trailing edge
// - enable active half period before first edge
// - enable released half period after last edge
// - enable stays active between back-to-back words
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// small word buffer with valid and ready on both sides
module smpz_fifo
   import smpz_pkg::*;
#(
   parameter int W = 8,
   parameter int DEPTH = 2
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem; // storage
      logic [PW-1:0] wr_ptr; // next slot to fill
      logic [PW-1:0] rd_ptr; // oldest slot
      logic [PW:0] count; // words held
   } smpz_fifo_state_t;

   smpz_fifo_state_t st; // registered state
   smpz_fifo_state_t next_st; // next state
   logic push; // word accepted
   logic pop; // word drained

   // flags come from the count only, so no path runs through them
   assign in_ready_out = st.count != (PW+1)'(DEPTH);
   assign out_valid_out = st.count != '0;
   assign out_data_out = st.mem[st.rd_ptr];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // pointer and count update
   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.mem[st.wr_ptr] = in_data_in;
         next_st.wr_ptr = (st.wr_ptr == PW'(DEPTH - 1)) ? '0 : st.wr_ptr + PW'(1);
      end
      if (pop)
      begin
         next_st.rd_ptr = (st.rd_ptr == PW'(DEPTH - 1)) ? '0 : st.rd_ptr + PW'(1);
      end
      next_st.count = st.count + (PW+1)'(push) - (PW+1)'(pop);
   end

   // state register
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// serial master, phase zero, with register port
module smpz_top
   import smpz_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [SMPZ_ADDR_W-1:0] addr_in,
   input wire logic [SMPZ_DATA_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [SMPZ_DATA_W-1:0] rd_data_out,
   input wire logic master_in_line_in,
   output logic serial_clock_pin_out,
   output logic master_out_line_out,
   output logic slave_enable_pin_n_out
);

   typedef struct packed {
      smpz_state_t state; // shifter state
      logic [7:0] cfg; // config_control_reg
      logic [7:0] opctl; // operation_control_reg
      logic [6:0] baud; // baud_divider
      logic [7:0] rd_data; // read answer, one cycle after strobe
      logic [7:0] tx_word; // word being sent
      logic [7:0] rx_word; // bits gathered so far
      logic [2:0] bit_idx; // bit on the line
      logic [7:0] cnt; // cycles left in this half
      logic sclk; // serial clock level
      logic mosi; // outgoing data level
      logic en_n; // slave enable, low active
      logic miso_s1; // first sync stage
      logic miso_s2; // second sync stage
   } smpz_top_state_t;

   smpz_top_state_t st; // registered state
   smpz_top_state_t next_st; // next state
   logic pol; // idle clock level
   logic [7:0] period; // serial period in cycles
   logic [7:0] half_first; // non-idle half
   logic [7:0] half_second; // idle half
   logic start_ok; // a word may start now
   logic tx_valid; // transmit buffer not empty
   logic [7:0] tx_data; // head of transmit buffer
   logic tx_ready; // transmit buffer has room
   logic tx_push; // software write to transmit
   logic tx_pop; // shifter takes a word
   logic rx_valid; // receive buffer not empty
   logic [7:0] rx_data; // head of receive buffer
   logic rx_ready; // receive buffer has room
   logic rx_push; // shifter delivers a word
   logic rx_pop; // software reads a word
   logic [7:0] rx_full_word; // word with final bit added
   logic [2:0] next_bit; // following bit index

   ////////////////////////////////////////////////////////////////////////////////
   // serial timing from the divider
   assign pol = st.cfg[SMPZ_POL_BIT];
   // small dividers fall back to the fixed four-cycle period
   assign period = (st.baud <= SMPZ_DIV_FIXED_MAX) ? SMPZ_FIXED_PERIOD
                 : {1'b0, st.baud} + 8'h01;
   // odd periods put the short half on the non-idle level
   assign half_first = period >> 1;
   assign half_second = period - half_first;
   assign next_bit = st.bit_idx + 3'h1;
   assign rx_full_word = {st.rx_word[6:0], st.miso_s2};
   assign tx_push = wr_in && (addr_in == SMPZ_ADDR_TX);
   // a word starts only if its answer has a slot, so no word is lost
   assign start_ok = st.opctl[SMPZ_ROLE_BIT] && !st.opctl[SMPZ_PHASE_BIT]
                   && tx_valid && rx_ready;

   ////////////////////////////////////////////////////////////////////////////////
   // word buffers on both sides of the shifter
   smpz_fifo #(.W(SMPZ_DATA_W), .DEPTH(SMPZ_BUF_DEPTH)) u_tx_buf (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .in_valid_in(tx_push),
      .in_ready_out(tx_ready),
      .in_data_in(wr_data_in),
      .out_valid_out(tx_valid),
      .out_ready_in(tx_pop),
      .out_data_out(tx_data)
   );

   smpz_fifo #(.W(SMPZ_DATA_W), .DEPTH(SMPZ_BUF_DEPTH)) u_rx_buf (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .in_valid_in(rx_push),
      .in_ready_out(rx_ready),
      .in_data_in(rx_full_word),
      .out_valid_out(rx_valid),
      .out_ready_in(rx_pop),
      .out_data_out(rx_data)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // register port and shifter next state
   always_comb
   begin
      next_st = st;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      // incoming line passes two stages before use
      next_st.miso_s1 = master_in_line_in;
      next_st.miso_s2 = st.miso_s1;
      // register writes; a write to a full transmit buffer is dropped
      if (wr_in)
      begin
         case (addr_in)
            SMPZ_ADDR_CFG: next_st.cfg = wr_data_in;
            SMPZ_ADDR_OPCTL: next_st.opctl = wr_data_in;
            SMPZ_ADDR_BAUD: next_st.baud = wr_data_in[SMPZ_BAUD_W-1:0];
            default: ; // transmit handled by buffer, rest ignored
         endcase
      end
      // read answer stands for one cycle only
      next_st.rd_data = '0;
      if (rd_in)
      begin
         case (addr_in)
            SMPZ_ADDR_CFG: next_st.rd_data = st.cfg;
            SMPZ_ADDR_OPCTL: next_st.rd_data = st.opctl;
            SMPZ_ADDR_BAUD: next_st.rd_data = {1'b0, st.baud};
            SMPZ_ADDR_RX:
            begin
               // empty buffer reads zero and pops nothing
               next_st.rd_data = rx_valid ? rx_data : '0;
               rx_pop = rx_valid;
            end
            SMPZ_ADDR_STAT:
            begin
               next_st.rd_data[SMPZ_STAT_TXROOM] = tx_ready;
               next_st.rd_data[SMPZ_STAT_RXVALID] = rx_valid;
               next_st.rd_data[SMPZ_STAT_BUSY] = st.state != ST_IDLE;
            end
            default: next_st.rd_data = '0; // unmapped reads zero
         endcase
      end
      // shifter
      case (st.state)
         ST_IDLE:
         begin
            next_st.sclk = pol;
            next_st.en_n = 1'b1;
            if (start_ok)
            begin
               // enable and first bit go out half a period early
               tx_pop = 1'b1;
               next_st.tx_word = tx_data;
               next_st.mosi = tx_data[SMPZ_LAST_BIT];
               next_st.en_n = 1'b0;
               next_st.cnt = half_second - 8'h01;
               next_st.state = ST_LEAD;
            end
         end
         ST_LEAD:
         begin
            if (st.cnt == '0)
            begin
               // first leading edge; the first bit is already out
               next_st.sclk = !pol;
               next_st.mosi = st.tx_word[SMPZ_LAST_BIT];
               next_st.bit_idx = '0;
               next_st.cnt = half_first - 8'h01;
               next_st.state = ST_ACTIVE;
            end
            else
            begin
               next_st.cnt = st.cnt - 8'h01;
            end
         end
         ST_ACTIVE:
         begin
            if (st.cnt == '0)
            begin
               // trailing edge samples the incoming line
               next_st.sclk = pol;
               next_st.rx_word = rx_full_word;
               rx_push = st.bit_idx == SMPZ_LAST_BIT;
               next_st.cnt = half_second - 8'h01;
               next_st.state = ST_IDLEHALF;
            end
            else
            begin
               next_st.cnt = st.cnt - 8'h01;
            end
         end
         ST_IDLEHALF:
         begin
            if (st.cnt != '0)
            begin
               next_st.cnt = st.cnt - 8'h01;
            end
            else if (st.bit_idx != SMPZ_LAST_BIT)
            begin
               // next bit launched on the leading edge
               next_st.bit_idx = next_bit;
               next_st.sclk = !pol;
               next_st.mosi = st.tx_word[SMPZ_LAST_BIT - next_bit];
               next_st.cnt = half_first - 8'h01;
               next_st.state = ST_ACTIVE;
            end
            else if (start_ok)
            begin
               // next word joins without dropping the enable
               tx_pop = 1'b1;
               next_st.tx_word = tx_data;
               next_st.bit_idx = '0;
               next_st.sclk = !pol;
               next_st.mosi = tx_data[SMPZ_LAST_BIT];
               next_st.cnt = half_first - 8'h01;
               next_st.state = ST_ACTIVE;
            end
            else
            begin
               // half a period after the last sampling edge
               next_st.en_n = 1'b1;
               next_st.state = ST_IDLE;
            end
         end
         default: next_st.state = ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st <= '0;
         st.state <= ST_IDLE;
         st.cfg <= SMPZ_CFG_RESET;
         st.opctl <= SMPZ_OPCTL_RESET;
         st.baud <= SMPZ_BAUD_RESET;
         st.en_n <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // every output straight from a flop
   assign rd_data_out = st.rd_data;
   assign serial_clock_pin_out = st.sclk;
   assign master_out_line_out = st.mosi;
   assign slave_enable_pin_n_out = st.en_n;

   ////////////////////////////////////////////////////////////////////////////////
   // checks; divider and polarity assumed steady while a word runs
   logic prev_sclk; // clock level one cycle back
   logic prev_en_n; // enable one cycle back
   logic [7:0] run_len; // cycles since last clock change or enable fall
   logic lead; // leading edge shown this cycle
   logic trail; // trailing edge shown this cycle

   // only inside a frame, so an idle polarity change is not taken for an edge
   assign lead = (st.sclk != prev_sclk) && (st.sclk != pol) && !st.en_n;
   assign trail = (st.sclk != prev_sclk) && (st.sclk == pol) && !st.en_n;

   // helper history, read by the checks only
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         prev_sclk <= 1'b0;
         prev_en_n <= 1'b1;
         run_len <= 8'h01;
      end
      else
      begin
         prev_sclk <= st.sclk;
         prev_en_n <= st.en_n;
         if ((st.sclk != prev_sclk) || (!st.en_n && prev_en_n))
            run_len <= 8'h01;
         else if (run_len != 8'hFF)
            run_len <= run_len + 8'h01;
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_period_floor: assert property (lead |-> ##1 (!lead)[*3])
      else $error("serial period shorter than four cycles");
   a_active_half: assert property (trail |-> run_len == half_first)
      else $error("non-idle half has wrong length");
   a_idle_half: assert property (lead |-> run_len == half_second)
      else $error("idle half has wrong length");
   a_idle_level: assert property ((st.en_n && prev_en_n && $stable(pol)) |-> st.sclk == pol)
      else $error("idle clock level does not follow polarity");
   a_master_only: assert property ((!st.opctl[SMPZ_ROLE_BIT] && st.state == ST_IDLE)
      |=> slave_enable_pin_n_out)
      else $error("word started while not master");
   a_data_launch: assert property ($changed(master_out_line_out)
      |-> (lead || $fell(slave_enable_pin_n_out)))
      else $error("outgoing data changed off the leading edge");
   a_sample_edge: assert property (rx_push |=> trail)
      else $error("word delivered off the trailing edge");
   a_enable_lead: assert property ($fell(slave_enable_pin_n_out) |-> (!lead)[*2])
      else $error("clock edge too soon after enable");
   a_release_tail: assert property ($rose(slave_enable_pin_n_out)
      |-> (run_len == half_second && prev_sclk == pol))
      else $error("enable released at wrong time");
   a_back_to_back: assert property ((st.state == ST_IDLEHALF && st.cnt == '0
      && st.bit_idx == SMPZ_LAST_BIT && start_ok) |=> (!slave_enable_pin_n_out && lead))
      else $error("enable dropped between words");
   a_msb_first: assert property ((lead && $past(st.state == ST_LEAD))
      |-> master_out_line_out == st.tx_word[SMPZ_LAST_BIT])
      else $error("first bit is not the top bit");
endmodule

// ### verification/smpz_slave_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// serial slave on the far side; it only follows the block's clock
module smpz_slave_model
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic pol_in,
   input wire logic sclk_in,
   input wire logic mosi_in,
   input wire logic en_n_in,
   input wire logic [7:0] word_in,
   output logic miso_out,
   output logic [7:0] rx_word_out
);
   logic prev_sclk; // clock one cycle ago
   logic framed; // inside a frame
   logic [2:0] cnt; // bits taken in this word
   logic [7:0] shreg; // bits still to send
   logic [7:0] rxreg; // bits taken so far

   // sees edges one cycle late, like a slow real slave
   always_ff @(posedge clk_in)
   begin
      prev_sclk <= sclk_in;
      if (rst_in)
      begin
         framed <= 1'b0;
         cnt <= 3'h0;
         miso_out <= 1'b0;
         rx_word_out <= 8'h00;
      end
      else if (en_n_in)
      begin
         // released line toggles, so a stale bit is never read as data
         framed <= 1'b0;
         cnt <= 3'h0;
         miso_out <= ~miso_out;
      end
      else if (!framed)
      begin
         // first bit goes out as soon as the frame opens
         framed <= 1'b1;
         miso_out <= word_in[7];
         shreg <= {word_in[6:0], 1'b0};
      end
      else if (prev_sclk != pol_in && sclk_in == pol_in)
      begin
         // after a sampling edge: take the bit, then move ours on
         rxreg <= {rxreg[6:0], mosi_in};
         cnt <= cnt + 3'h1;
         miso_out <= (cnt == 3'h7) ? word_in[7] : shreg[7];
         shreg <= (cnt == 3'h7) ? {word_in[6:0], 1'b0} : {shreg[6:0], 1'b0};
         if (cnt == 3'h7)
            rx_word_out <= {rxreg[6:0], mosi_in};
      end
   end
endmodule

// ### verification/tb_smpz_top.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("CHECK FAILED %s expected %0h seen %0h", nm, (exp), (got)); \
      end \
   end

module tb_smpz_top;
   import smpz_pkg::*;
   logic clk_in;
   logic rst_in;
   logic [SMPZ_ADDR_W-1:0] addr;
   logic [SMPZ_DATA_W-1:0] wr_data;
   logic wr;
   logic rd;
   logic [SMPZ_DATA_W-1:0] rd_data;
   logic miso;
   logic sclk;
   logic mosi;
   logic en_n;
   logic pol; // polarity last set
   logic [7:0] slave_word; // word the slave returns
   logic [7:0] slave_rx; // last word the slave took
   int error_cnt;
   int num_checks;
   int cycles;

   smpz_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wr_data),
      .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data), .master_in_line_in(miso),
      .serial_clock_pin_out(sclk), .master_out_line_out(mosi), .slave_enable_pin_n_out(en_n));

   smpz_slave_model slave_u (.clk_in(clk_in), .rst_in(rst_in), .pol_in(pol), .sclk_in(sclk),
      .mosi_in(mosi), .en_n_in(en_n), .word_in(slave_word), .miso_out(miso),
      .rx_word_out(slave_rx));

   ////////////////////////////////////////////////////////////////////////////////
   // clock, hang guard and verdict
   initial
   begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // longest run is well under this ceiling
   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         error_cnt++;
         summarize();
      end
   end

   task summarize;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // register port, one strobe per call
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wr_data <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      d = rd_data;
   endtask

   task automatic t_regs;
      logic [7:0] d;
      `CHK("reset clock", 1'b0, sclk)
      `CHK("reset enable", 1'b1, en_n)
      rd_reg(SMPZ_ADDR_CFG, d);
      `CHK("cfg reset", 8'h00, d)
      rd_reg(SMPZ_ADDR_OPCTL, d);
      `CHK("opctl reset", 8'h00, d)
      wr_reg(SMPZ_ADDR_BAUD, 8'hFF);
      rd_reg(SMPZ_ADDR_BAUD, d);
      `CHK("baud field", 8'h7F, d)
      wr_reg(SMPZ_ADDR_STAT, 8'hFF);
      rd_reg(SMPZ_ADDR_STAT, d);
      `CHK("status ro", 8'h01, d)
      rd_reg(3'h6, d);
      `CHK("unmapped", 8'h00, d)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // words pushed while no word can start (master off, or phase one), then released; pins timed cycle by cycle
   task automatic run_word(input logic pl, input logic [6:0] baud, input logic [7:0] mw,
      input int nw, input logic phase);
      int p;
      int h1;
      int h2;
      int t;
      int last;
      int lt;
      int nl;
      int nt;
      int k;
      logic prev;
      logic [7:0] wd;
      logic [7:0] d;
      p = (baud <= 7'h03) ? 4 : int'(baud) + 1;
      h1 = p / 2;
      h2 = p - h1;
      wr_reg(SMPZ_ADDR_CFG, {1'b0, pl, 6'h00});
      pol <= pl;
      // slowest rate here is far below the limits
      wr_reg(SMPZ_ADDR_BAUD, {1'b0, baud});
      wr_reg(SMPZ_ADDR_OPCTL, phase ? 8'h0C : 8'h00);
      slave_word <= {mw[3:0], mw[7:4]};
      for (k = 0; k < nw; k++)
         wr_reg(SMPZ_ADDR_TX, (k == 0) ? mw : ~mw);
      // a third word into a full buffer is dropped
      if (nw == 2)
         wr_reg(SMPZ_ADDR_TX, 8'hFF);
      rd_reg(SMPZ_ADDR_STAT, d);
      `CHK("status full", (nw == 2) ? 8'h00 : 8'h01, d)
      `CHK("idle clock", pl, sclk)
      if (phase)
      begin
         repeat (40) @(posedge clk_in);
         #1;
         `CHK("phase one idle", 1'b1, en_n)
      end
      wr_reg(SMPZ_ADDR_OPCTL, 8'h04);
      k = 0;
      #1;
      while (en_n !== 1'b0 && k < 50)
      begin
         @(posedge clk_in);
         #1;
         k++;
      end
      `CHK("enable fall", 1'b0, en_n)
      `CHK("first bit", mw[7], mosi)
      t = 0;
      last = 0;
      lt = 0;
      nl = 0;
      nt = 0;
      prev = sclk;
      while (nt < 8 * nw && t < 3000)
      begin
         @(posedge clk_in);
         #1;
         t++;
         if (en_n !== 1'b0) `CHK("enable held", 1'b0, en_n)
         if (sclk !== prev && sclk !== pl)
         begin
            if (nl == 0) `CHK("lead in", h2, t - last)
            else `CHK("period", p, t - last)
            wd = (nl < 8) ? mw : ~mw;
            `CHK("data bit", wd[7 - nl % 8], mosi)
            last = t;
            nl++;
         end
         else if (sclk !== prev)
         begin
            `CHK("active half", h1, t - last)
            lt = t;
            nt++;
         end
         prev = sclk;
      end
      while (en_n === 1'b0 && t < 3000)
      begin
         @(posedge clk_in);
         #1;
         t++;
      end
      `CHK("enable tail", h2, t - lt)
      `CHK("idle after", pl, sclk)
      `CHK("slave got", wd, slave_rx)
      for (k = 0; k < nw; k++)
      begin
         rd_reg(SMPZ_ADDR_RX, d);
         `CHK("rx word", {mw[3:0], mw[7:4]}, d)
      end
      rd_reg(SMPZ_ADDR_RX, d);
      `CHK("rx empty", 8'h00, d)
      rd_reg(SMPZ_ADDR_STAT, d);
      `CHK("status idle", 8'h01, d)
      `CHK("no extra word", 1'b1, en_n)
   endtask

   initial
   begin
      addr = 3'h0;
      wr_data = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      rst_in = 1'b1;
      pol = 1'b0;
      slave_word = 8'h00;
      error_cnt = 0;
      num_checks = 0;
      cycles = 0;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      #1;
      t_regs();
      run_word(1'b0, 7'h00, 8'hA5, 1, 1'b1);
      run_word(1'b1, 7'h02, 8'h3C, 1, 1'b0);
      run_word(1'b0, 7'h03, 8'hC3, 1, 1'b0);
      run_word(1'b0, 7'h04, 8'h96, 1, 1'b0);
      run_word(1'b1, 7'h07, 8'h5A, 2, 1'b0);
      run_word(1'b1, 7'h08, 8'hE7, 2, 1'b0);
      run_word(1'b0, 7'h7F, 8'h81, 1, 1'b0);
      summarize();
   end
endmodule
